// >>> cfg_sync_regs.svh
// constants for the configuration sync word and bus width detector
//
// Functional notes
// RULE1 - bus width is found by the block itself from the sync byte sequence
// RULE2 - x8 mode needs 0xAA, 0x99, 0x55, 0x66 on the low byte in successive beats
// RULE3 - x16 mode needs low byte 0x99 then 0x66; other sync bytes ride upper lanes
// RULE4 - after detection every beat is received at the detected width
// RULE5 - all data is ignored and no packet is handled before the full sync word
// RULE6 - pins carry each byte bit-reversed; sender presents it in that order
// RULE7 - stream mixes commands and data; commands are interpreted, never stored
// RULE8 - once finished, any stream that follows directly is ignored
// RULE9 - chained downstream streams must be nested in packets, not concatenated
// RULE10 - one byte per configuration clock in x8; byte msb sits on data pin zero
// RULE11 - x16 source drives 0x5599 then 0xaa66 on the pins
// RULE12 - all-ones pads never advance detection; a mismatch restarts the search
`ifndef CFG_SYNC_REGS_SVH
`define CFG_SYNC_REGS_SVH

// ----------------------------------------
// sync word bytes, logical order
// ----------------------------------------
`define SYNC_B0 8'haa
`define SYNC_B1 8'h99
`define SYNC_B2 8'h55
`define SYNC_B3 8'h66
`define PAD_BYTE 8'hff

// ----------------------------------------
// stream word layout
// ----------------------------------------
`define WORD_W 32
`define PIN_W 16
`define CMD_OP_MSB 31
`define CMD_OP_LSB 24
`define CMD_CNT_MSB 15
`define CMD_CNT_LSB 0
`define CMD_END_OP 8'h0f

// ----------------------------------------
// buffering and pin synchroniser
// ----------------------------------------
`define FIFO_DEPTH_DEF 16
`define FIFO_SLACK 4
`define SYNC_STAGES 2

`endif

// >>> cfg_sync_pkg.sv
// types shared by the configuration sync detector
package cfg_sync_pkg;

  // one-hot detector states
  typedef enum logic [7:0] {
    ST_HUNT = 8'h01,
    ST_X8_AA = 8'h02,
    ST_X8_99 = 8'h04,
    ST_X8_55 = 8'h08,
    ST_X16_99 = 8'h10,
    ST_RUN8 = 8'h20,
    ST_RUN16 = 8'h40,
    ST_DONE = 8'h80
  } det_state_t;

  typedef enum logic [1:0] {
    BW_NONE = 2'h0,
    BW_X8 = 2'h1,
    BW_X16 = 2'h2
  } bus_width_t;

  // configuration pins as sampled
  typedef struct packed {
    logic clk;
    logic [15:0] data;
  } pin_beat_t;

  // interpreted command word
  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } cmd_t;

endpackage

// >>> pin_sync.sv
// two-stage synchroniser for configuration pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 17
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [W-1:0] pins_i,
  output logic [W-1:0] pins_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // meta_q feeds sync_q only
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce_i) begin
      meta_q <= pins_i;
      sync_q <= meta_q;
    end
  end

  assign pins_o = sync_q;

endmodule

// >>> word_fifo.sv
// word fifo with registered output stage
`timescale 1ns/100ps
module word_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16,
  parameter int SLACK = 4
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic almost_full_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic ov_q;
  logic [W-1:0] od_q;

  wire push_w = in_valid_i & in_ready_o;
  wire load_w = (count_q != '0) & (~ov_q | out_ready_i);

  assign in_ready_o = (count_q < (AW+1)'(DEPTH));
  // early warning: the source sees busy only after the pin round trip
  assign almost_full_o = (count_q >= (AW+1)'(DEPTH - SLACK));
  assign out_valid_o = ov_q;
  assign out_data_o = od_q;

  always_ff @(posedge mclk_i) begin
    if (ce_i && push_w) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else if (ce_i) begin
      if (push_w) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (load_w) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
        od_q <= mem[rd_ptr_q];
        ov_q <= 1'b1;
      end else if (out_ready_i) begin
        ov_q <= 1'b0;
      end
      count_q <= count_q + (AW+1)'(push_w) - (AW+1)'(load_w);
    end
  end

endmodule

// >>> cfg_sync_detect.sv
// sync word search, bus width detection and stream split for parallel loading
`timescale 1ns/100ps
`include "cfg_sync_regs.svh"
module cfg_sync_detect
  import cfg_sync_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF,
  parameter int FIFO_SLACK = `FIFO_SLACK
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic cfg_clk_i,
  input wire logic [15:0] cfg_data_i,
  output logic busy_o,
  output logic synced_o,
  output bus_width_t width_o,
  output logic done_o,
  output cmd_t cmd_o,
  output logic data_valid_o,
  output logic [31:0] data_o,
  input wire logic data_ready_i,
  output logic overflow_o
);

  // ----------------------------------------
  // pin capture
  // ----------------------------------------
  pin_beat_t pins_s;
  logic clk_prev_q;

  pin_sync #(
    .W($bits(pin_beat_t))
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .pins_i({cfg_clk_i, cfg_data_i}),
    .pins_o(pins_s)
  );

  // one beat per rising edge of the configuration clock
  wire beat_w = ce_i & pins_s.clk & ~clk_prev_q; // RULE10

  // pin zero carries the byte msb, so each lane is reversed
  logic [15:0] lane_rev;
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_W; gi++) begin : g_rev
      assign lane_rev[gi] = pins_s.data[(gi / 8) * 8 + 7 - (gi % 8)]; // RULE6
    end
  endgenerate

  wire [7:0] beat_lo = lane_rev[7:0];
  wire [7:0] beat_hi = lane_rev[15:8];

  // ----------------------------------------
  // detector state machine
  // ----------------------------------------
  det_state_t state_q;
  det_state_t state_d;
  det_state_t hunt_next;
  logic end_cmd_w;

  // a failed byte is re-examined as a possible first sync byte
  always_comb begin
    if (beat_lo == `SYNC_B0) begin
      hunt_next = ST_X8_AA; // RULE2
    end else if (beat_lo == `SYNC_B1) begin
      hunt_next = ST_X16_99; // RULE3
    end else begin
      hunt_next = ST_HUNT; // RULE12
    end
  end

  always_comb begin
    state_d = state_q;
    if (beat_w) begin
      case (state_q)
        ST_HUNT: begin
          state_d = hunt_next; // RULE1
        end
        ST_X8_AA: begin
          state_d = (beat_lo == `SYNC_B1) ? ST_X8_99 : hunt_next; // RULE12
        end
        ST_X8_99: begin
          state_d = (beat_lo == `SYNC_B2) ? ST_X8_55 : hunt_next; // RULE12
        end
        ST_X8_55: begin
          state_d = (beat_lo == `SYNC_B3) ? ST_RUN8 : hunt_next; // RULE2
        end
        ST_X16_99: begin
          state_d = (beat_lo == `SYNC_B3) ? ST_RUN16 : hunt_next; // RULE3
        end
        ST_RUN8, ST_RUN16: begin
          state_d = end_cmd_w ? ST_DONE : state_q; // RULE8
        end
        ST_DONE: begin
          state_d = ST_DONE; // RULE8
        end
        default: begin
          state_d = ST_HUNT;
        end
      endcase
    end
  end

  wire run8_w = (state_q == ST_RUN8);
  wire run16_w = (state_q == ST_RUN16);
  wire in_run_w = run8_w | run16_w; // RULE5

  bus_width_t width_d;
  assign width_d = (state_d == ST_RUN16) ? BW_X16 :
                   (state_d == ST_RUN8) ? BW_X8 :
                   (state_d == ST_DONE) ? width_o : BW_NONE;

  // ----------------------------------------
  // word assembly at the detected width
  // ----------------------------------------
  logic [1:0] lane_cnt_q;
  logic [31:0] asm_q;
  logic [15:0] left_q;

  // first beat lands in the most significant part of the word
  wire [31:0] asm_next_w = run16_w ? {asm_q[15:0], beat_hi, beat_lo} :
                                     {asm_q[23:0], beat_lo}; // RULE4
  wire word_last_w = run16_w ? lane_cnt_q[0] : (lane_cnt_q == 2'h3); // RULE4
  wire word_fire_w = beat_w & in_run_w & word_last_w;

  // ----------------------------------------
  // command and data split
  // ----------------------------------------
  // a command carries the number of data words that follow it
  wire is_cmd_w = (left_q == 16'h0000);
  wire cmd_fire_w = word_fire_w & is_cmd_w; // RULE7
  wire [7:0] op_w = asm_next_w[`CMD_OP_MSB:`CMD_OP_LSB];
  assign end_cmd_w = cmd_fire_w & (op_w == `CMD_END_OP); // RULE8
  wire fifo_ready_w;
  wire fifo_afull_w;
  wire push_w = word_fire_w & ~is_cmd_w & fifo_ready_w; // RULE7
  // no way to stall the pins: a word that meets a full fifo is lost
  wire drop_w = word_fire_w & ~is_cmd_w & ~fifo_ready_w;

  word_fifo #(
    .W(`WORD_W),
    .DEPTH(FIFO_DEPTH),
    .SLACK(FIFO_SLACK)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .in_valid_i(push_w),
    .in_data_i(asm_next_w),
    .in_ready_o(fifo_ready_w),
    .almost_full_o(fifo_afull_w),
    .out_valid_o(data_valid_o),
    .out_data_o(data_o),
    .out_ready_i(data_ready_i)
  );

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_HUNT;
      clk_prev_q <= 1'b0;
    end else if (ce_i) begin
      state_q <= state_d;
      clk_prev_q <= pins_s.clk;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lane_cnt_q <= 2'h0;
      asm_q <= 32'h0000_0000;
    end else if (beat_w && in_run_w) begin
      lane_cnt_q <= lane_cnt_q + 2'h1;
      asm_q <= asm_next_w; // RULE4
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      left_q <= 16'h0000;
    end else if (cmd_fire_w) begin
      left_q <= asm_next_w[`CMD_CNT_MSB:`CMD_CNT_LSB];
    end else if (word_fire_w) begin
      left_q <= left_q - 16'h0001;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_o <= '0;
      width_o <= BW_NONE;
      synced_o <= 1'b0;
      done_o <= 1'b0;
      busy_o <= 1'b0;
      overflow_o <= 1'b0;
    end else if (ce_i) begin
      cmd_o.valid <= cmd_fire_w; // RULE7
      if (cmd_fire_w) begin
        cmd_o.word <= asm_next_w;
      end
      width_o <= width_d; // RULE1
      synced_o <= (state_d == ST_RUN8) | (state_d == ST_RUN16) | (state_d == ST_DONE);
      done_o <= (state_d == ST_DONE);
      busy_o <= fifo_afull_w;
      overflow_o <= overflow_o | drop_w;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // independent beat count per word, read only by the checks
  logic [2:0] chk_beats_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chk_beats_q <= 3'h0;
    end else if (beat_w && in_run_w) begin
      chk_beats_q <= word_fire_w ? 3'h0 : chk_beats_q + 3'h1;
    end
  end

  chk_x8_commit: assert property ( // RULE2
    (state_q == ST_RUN8 && $past(state_q) != ST_RUN8)
      |-> ($past(state_q) == ST_X8_55 && $past(beat_lo) == `SYNC_B3))
    else $error("x8 mode entered without the full byte sequence");

  chk_x16_commit: assert property ( // RULE3
    (state_q == ST_RUN16 && $past(state_q) != ST_RUN16)
      |-> ($past(state_q) == ST_X16_99 && $past(beat_lo) == `SYNC_B3))
    else $error("x16 mode entered without 0x99 then 0x66");

  chk_width_state: assert property ( // RULE1
    (state_q == ST_RUN16) |-> (width_o == BW_X16 && synced_o))
    else $error("width output disagrees with detector state");

  chk_no_cmd_early: assert property ( // RULE5
    cmd_o.valid |-> $past(in_run_w))
    else $error("command issued before sync word was found");

  chk_x8_beats: assert property ( // RULE4
    (word_fire_w && run8_w) |-> (chk_beats_q == 3'h3))
    else $error("x8 word completed on wrong beat");

  chk_x16_beats: assert property ( // RULE4
    (word_fire_w && run16_w) |-> (chk_beats_q == 3'h1))
    else $error("x16 word completed on wrong beat");

  chk_x8_width: assert property ( // RULE1
    (state_q == ST_RUN8) |-> (width_o == BW_X8 && synced_o))
    else $error("width output disagrees with x8 state");

  chk_pad_hold: assert property ( // RULE12
    (beat_w && state_q == ST_HUNT && beat_lo == `PAD_BYTE) |=> (state_q == ST_HUNT))
    else $error("pad byte advanced detection");

  chk_mismatch_restart: assert property ( // RULE12
    (beat_w && state_q == ST_X8_99 && beat_lo != `SYNC_B2 && beat_lo != `SYNC_B0
      && beat_lo != `SYNC_B1) |=> (state_q == ST_HUNT))
    else $error("mismatch did not restart the search");

  chk_done_ignore: assert property ( // RULE8
    (state_q == ST_DONE) |-> (!push_w && !cmd_fire_w) ##1 (state_q == ST_DONE))
    else $error("stream accepted after completion");

  chk_cmd_not_data: assert property ( // RULE7
    cmd_fire_w |-> ##1 (cmd_o.valid && cmd_o.word == $past(asm_next_w)) && !$past(push_w))
    else $error("command word stored as data");

  chk_bit_order: assert property ( // RULE10
    beat_w |-> (beat_lo[7] == pins_s.data[0] && beat_lo[0] == pins_s.data[7]))
    else $error("byte msb not taken from pin zero");

  chk_x16_restart: assert property ( // RULE12
    (beat_w && state_q == ST_X16_99 && beat_lo != `SYNC_B3 && beat_lo != `SYNC_B0
      && beat_lo != `SYNC_B1) |=> (state_q == ST_HUNT))
    else $error("x16 mismatch did not restart the search");

  chk_ce_freeze: assert property (
    !ce_i |=> ($stable(state_q) && $stable(synced_o) && $stable(width_o)))
    else $error("state moved while clock enable was low");

  chk_drop_flag: assert property (
    drop_w |=> overflow_o)
    else $error("lost data word not flagged");

  cov_x8_sync: cover property (state_q == ST_X8_55 ##1 state_q == ST_RUN8);
  cov_x16_sync: cover property (state_q == ST_X16_99 ##1 state_q == ST_RUN16);
  cov_done: cover property (in_run_w ##1 state_q == ST_DONE);
  cov_busy: cover property (busy_o && data_valid_o && !data_ready_i);
  cov_restart: cover property (state_q == ST_X8_99 ##1 state_q == ST_HUNT);

endmodule

// >>> cfg_source.sv
// parallel configuration data source model
`timescale 1ns/100ps
module cfg_source (
  input wire logic mclk_i,
  output logic cfg_clk_o,
  output logic [15:0] cfg_data_o
);
  // ------
  // beats
  // ------
  int hold_cycles = 3;
  initial begin
    cfg_clk_o = 1'b0;
    cfg_data_o = 16'hffff;
  end
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = b[7-i];
    end
  endfunction
  // lanes are logical bytes {upper, lower}; pins carry them bit-reversed
  task automatic beat(input logic [15:0] lanes);
    @(posedge mclk_i);
    cfg_data_o <= {rev8(lanes[15:8]), rev8(lanes[7:0])};
    repeat (2) @(posedge mclk_i);
    cfg_clk_o <= 1'b1;
    repeat (hold_cycles) @(posedge mclk_i);
    cfg_clk_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
    // released pins float up to the pull-up level
    cfg_data_o <= 16'hffff;
  endtask
endmodule

// >>> tb_config_sync_bus_width_detect.sv
// self-checking bench for the sync word and bus width detector
`timescale 1ns/100ps
module tb_config_sync_bus_width_detect
  import cfg_sync_pkg::*;
;
  // ------
  // harness
  // ------
  typedef struct {logic x16; int pads; logic [31:0] dw; bus_width_t ew;} row_t;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic cfg_clk_i;
  logic [15:0] cfg_data_i;
  logic data_ready_i = 1'b1;
  logic busy_o, synced_o, done_o, data_valid_o, overflow_o;
  bus_width_t width_o;
  cmd_t cmd_o;
  logic [31:0] data_o;
  logic [31:0] rx_q[$];
  logic [31:0] last_cmd;
  logic [7:0] seq[15] = '{8'h99, 8'h12, 8'haa, 8'h99, 8'h12, 8'haa, 8'h99, 8'h55,
                          8'h00, 8'haa, 8'h99, 8'haa, 8'h99, 8'h55, 8'h66};
  int n_cmd, n_fail, check_count;
  row_t rows[4] = '{'{1'b0, 0, 32'h0123_4567, BW_X8}, '{1'b0, 2, 32'h8c31_e05a, BW_X8},
                    '{1'b1, 0, 32'h1e2d_3c4b, BW_X16}, '{1'b1, 2, 32'hc001_7f80, BW_X16}};

  always #5 mclk_i = ~mclk_i;

  cfg_source i_cfg_source (.mclk_i(mclk_i), .cfg_clk_o(cfg_clk_i), .cfg_data_o(cfg_data_i));

  cfg_sync_detect i_cfg_sync_detect (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cfg_clk_i(cfg_clk_i),
    .cfg_data_i(cfg_data_i), .busy_o(busy_o), .synced_o(synced_o), .width_o(width_o),
    .done_o(done_o), .cmd_o(cmd_o), .data_valid_o(data_valid_o), .data_o(data_o),
    .data_ready_i(data_ready_i), .overflow_o(overflow_o));

  always @(posedge mclk_i) begin
    if (cmd_o.valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd_o.word;
    end
    if (data_valid_o === 1'b1 && data_ready_i === 1'b1) begin
      rx_q.push_back(data_o);
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic do_reset(input int n);
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (n) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    rx_q.delete();
    n_cmd = 0;
  endtask

  task automatic send_word(input logic x16, input logic [31:0] w);
    if (x16) begin
      i_cfg_source.beat(w[31:16]);
      i_cfg_source.beat(w[15:0]);
    end else begin
      for (int k = 3; k >= 0; k--) begin
        i_cfg_source.beat({8'hff, w[8*k +: 8]});
      end
    end
  endtask

  initial begin
    repeat (30000) @(posedge mclk_i);
    n_fail++;
    end_sim();
  end

  // ------
  // tests
  // ------
  initial begin
    repeat (16) @(posedge mclk_i);
    check(32'(width_o), 32'(BW_NONE));
    check(32'(synced_o), 32'h0);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    check(32'({busy_o, done_o, data_valid_o, overflow_o, cmd_o.valid}), 32'h0);
    $display("reset test finished");
    foreach (rows[r]) begin
      do_reset(2);
      repeat (rows[r].pads) send_word(rows[r].x16, 32'hffff_ffff);
      check(32'(synced_o), 32'h0);
      send_word(rows[r].x16, 32'haa99_5566);
      check(32'(width_o), 32'(rows[r].ew));
      check(32'(synced_o), 32'h1);
      send_word(rows[r].x16, 32'h0100_0002);
      send_word(rows[r].x16, rows[r].dw);
      send_word(rows[r].x16, ~rows[r].dw);
      send_word(rows[r].x16, 32'h0f00_0000);
      repeat (4) @(posedge mclk_i);
      check(32'(done_o), 32'h1);
      check(32'(n_cmd), 32'h2);
      check(last_cmd, 32'h0f00_0000);
      check(32'(rx_q.size()), 32'h2);
      check(rx_q[0], rows[r].dw);
      check(rx_q[1], ~rows[r].dw);
      // a concatenated second stream after completion
      send_word(rows[r].x16, 32'haa99_5566);
      send_word(rows[r].x16, 32'h0100_0001);
      check(32'(n_cmd), 32'h2);
      check(32'(width_o), 32'(rows[r].ew));
      check(32'(rx_q.size()), 32'h2);
      $display("row %0d finished", r);
    end
    // slow source, junk and four broken syncs (one x16, three x8) before the real one
    do_reset(2);
    i_cfg_source.hold_cycles = 7;
    for (int i = 0; i < 15; i++) begin
      i_cfg_source.beat({8'hff, seq[i]});
      if (i == 5) check(32'(synced_o), 32'h0);
    end
    check(32'(width_o), 32'(BW_X8));
    check(32'(n_cmd), 32'h0);
    i_cfg_source.hold_cycles = 3;
    send_word(1'b0, 32'h0f00_0000);
    repeat (4) @(posedge mclk_i);
    check(32'(n_cmd), 32'h1);
    check(32'(rx_q.size()), 32'h0);
    $display("restart test finished");
    // consumer stalls while a nested downstream block fills the buffer
    do_reset(2);
    data_ready_i <= 1'b0;
    send_word(1'b1, 32'haa99_5566);
    send_word(1'b1, 32'h0200_0014);
    for (int k = 0; k < 20; k++) begin
      send_word(1'b1, 32'h5a00_0000 + 32'(k));
    end
    check(32'(busy_o), 32'h1);
    check(32'(overflow_o), 32'h1);
    check(32'(data_valid_o), 32'h1);
    data_ready_i <= 1'b1;
    repeat (40) @(posedge mclk_i);
    check(rx_q[0], 32'h5a00_0000);
    check(32'(rx_q.size()), 32'h11);
    check(rx_q[16], 32'h5a00_0010);
    check(32'(busy_o), 32'h0);
    check(32'(data_valid_o), 32'h0);
    $display("buffer test finished");
    // clock enable low: pins are not sampled at all, so a whole sync word is missed
    do_reset(2);
    ce_i <= 1'b0;
    send_word(1'b0, 32'haa99_5566);
    ce_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    check(32'(synced_o), 32'h0);
    check(32'(width_o), 32'(BW_NONE));
    send_word(1'b0, 32'haa99_5566);
    check(32'(width_o), 32'(BW_X8));
    $display("clock enable test finished");
    end_sim();
  end
endmodule
